/* File: hdl/pjs_cfg.svh */
// Offsets, field positions, reset values and encodings of the selector block.
// Assumes byte addresses on the sequencer register port and 40 MHz core_clk.
// How it works
// R1: Enabled mismatch jumps instead of interrupting, after residue.
// R2: Mode clear: residue flag picks address one/two.
// R3: Mode set: outbound uses one, inbound uses two.
// R4: Decisions use instruction phase, not bus phase.
// R5: Non-data jump only when its enable set.
// R6: Data-out mismatch clears FIFO unless disabled.
// R7: RAM load/store stays internal unless disabled.
// R8: Pipelined request held off while other function masters, only when its control bit set.
// R9: High-impedance floats pins; test pin shows AND-tree.
// R10: DAC disable suppresses every dual address cycle.
// R11: Index mode 0 picks one of 22 selectors.
// R12: Index mode 1 copies upper byte, 40-bit.
// R13: Count from dword0 low, address from dword1.
// R14: Table moves use entry byte or static selector.
// R15: Direct moves use instruction form or static selector.
// R16: Zero selector gives single cycle, else DAC.
// R17: Selectors reset zero; scratch starts undefined.
// R18: Host touches selectors only while sequencer halted.
// R19: No operation may cross an upper-dword boundary.
// R20: Read, write, relative selectors feed their operations.
// R21: Fetch selector feeds fetches, reloads, shadows identity.
// R22: Dynamic selector reloads per wide direct move.
// R23: Chosen selector copied to current register first.
// R24: Scratch changes only through register writes.
`ifndef PJS_CFG_SVH
`define PJS_CFG_SVH

`define PJS_OFF_CTL0 8'h56
`define PJS_OFF_CTL1 8'h57
`define PJS_OFF_SCR_LO 8'h60
`define PJS_OFF_SCR_HI 8'h9f
`define PJS_OFF_MMR 8'ha0
`define PJS_OFF_MMW 8'ha4
`define PJS_OFF_FETCH 8'ha8
`define PJS_OFF_REL 8'hac
`define PJS_OFF_STAT 8'hb0
`define PJS_OFF_DYN 8'hb4
`define PJS_OFF_CUR 8'hb8

`define PJS_CTL0_RST 8'h00
`define PJS_CTL1_RST 8'h00
`define PJS_SEL_RST 32'h0000_0000
`define PJS_CTL0_MASK 8'hf3
`define PJS_CTL1_MASK 8'h8f

`define PJS_B_JUMP_EN 7
`define PJS_B_JUMP_SEL 6
`define PJS_B_NONDATA 5
`define PJS_B_NOCLEAR 4
`define PJS_B_NO_INT_LS 1
`define PJS_B_NO_PREQ 0
`define PJS_B_HIZ 7
`define PJS_B_NO_DAC 3
`define PJS_B_IDX_MODE 2
`define PJS_B_WIDE_TAB 1
`define PJS_B_WIDE_DIR 0

`define PJS_TI_IDX_HI 28
`define PJS_TI_IDX_LO 24
`define PJS_TI_UP_HI 31
`define PJS_TI_UP_LO 24
`define PJS_TI_CNT_HI 23
`define PJS_SEL_COUNT 5'd22
`define PJS_SEL_FIXED 5'd6
`define PJS_PH_DATA_OUT 3'h0
`define PJS_TREE_W 16

`endif

/* File: hdl/pjs_pkg.sv */
// Types shared by the selector block and its picker.
// Assumes the constants header is included where numbers are needed.
package pjs_pkg;

	// Kind of master operation the sequencer is about to start.
	typedef enum logic [3:0] {
		pjs_op_fetch,
		pjs_op_ind_fetch,
		pjs_op_table_fetch,
		pjs_op_rel_ls,
		pjs_op_mm_read,
		pjs_op_mm_write,
		pjs_op_abs_load,
		pjs_op_abs_store,
		pjs_op_move_direct,
		pjs_op_move_indirect,
		pjs_op_move_table
	} pjs_op_type;

	// Mismatch handling sequence.
	typedef enum logic {
		pjs_idle,
		pjs_calc
	} pjs_state_type;

endpackage

/* File: hdl/pjs_sel.sv */
// Combinational picker of the upper address dword for one master operation.
// Assumes all selector and scratch values are stable registers of core_clk.
`timescale 1ns/1ps
`include "pjs_cfg.svh"

module pjs_sel import pjs_pkg::*; (
	input wire pjs_op_type op_kind,
	input wire logic [31:0] move_read_selector,
	input wire logic [31:0] move_write_selector,
	input wire logic [31:0] fetch_selector,
	input wire logic [31:0] relative_base_selector,
	input wire logic [31:0] static_move_selector,
	input wire logic [31:0] dynamic_move_selector,
	input wire logic [31:0] scratch [16],
	input wire logic [31:0] entry_dword0,
	input wire logic [31:0] instr_upper,
	input wire logic wide_table_move_enable,
	input wire logic wide_direct_move_enable,
	input wire logic table_index_mode,
	output logic [31:0] sel_value
);

	logic [4:0] idx;

	// Chooses the selector that belongs to the operation.
	always_comb begin
		idx = entry_dword0[`PJS_TI_IDX_HI:`PJS_TI_IDX_LO];
		sel_value = `PJS_SEL_RST;
		case (op_kind)
			pjs_op_fetch, pjs_op_ind_fetch: sel_value = fetch_selector; // R21
			pjs_op_table_fetch, pjs_op_rel_ls: sel_value = relative_base_selector; // R20
			pjs_op_mm_read, pjs_op_abs_load: sel_value = move_read_selector; // R20
			pjs_op_mm_write, pjs_op_abs_store: sel_value = move_write_selector; // R20
			pjs_op_move_direct: begin
				// The wide form carries its own upper dword.
				sel_value = wide_direct_move_enable ? instr_upper : static_move_selector; // R15
			end
			pjs_op_move_indirect: sel_value = static_move_selector;
			pjs_op_move_table: begin
				if (!wide_table_move_enable) begin
					sel_value = static_move_selector; // R14
				end else if (table_index_mode) begin
					sel_value = {24'h00_0000, entry_dword0[`PJS_TI_UP_HI:`PJS_TI_UP_LO]}; // R12
				end else if (idx < `PJS_SEL_FIXED) begin
					// Indices 0 to 5 name the six selectors in address order.
					case (idx)
						5'h00: sel_value = move_read_selector; // R11
						5'h01: sel_value = move_write_selector;
						5'h02: sel_value = fetch_selector;
						5'h03: sel_value = relative_base_selector;
						5'h04: sel_value = static_move_selector;
						default: sel_value = dynamic_move_selector;
					endcase
				end else if (idx < `PJS_SEL_COUNT) begin
					sel_value = scratch[4'(idx - `PJS_SEL_FIXED)]; // R11
				end else begin
					sel_value = `PJS_SEL_RST;
				end
			end
			default: sel_value = `PJS_SEL_RST;
		endcase
	end

endmodule

/* File: hdl/pjs_top.sv */
// Chip control registers, mismatch jump decision and 64-bit selector set.
// Assumes sequencer and DMA signals are on core_clk; AND-tree pins are not.
`timescale 1ns/1ps
`include "pjs_cfg.svh"

module pjs_top import pjs_pkg::*; #(
	parameter logic [15:0] DEVICE_CODE = 16'h1234, // Arbitrary value.
	parameter logic [7:0] REVISION_CODE = 8'h01 // Arbitrary value.
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	input wire logic config_shadow_enable,
	input wire logic mismatch_event,
	input wire logic [2:0] instr_phase,
	input wire logic wide_residue_flag,
	input wire logic residue_done,
	input wire logic [31:0] jump_address_one,
	input wire logic [31:0] jump_address_two,
	output logic jump_take,
	output logic [31:0] jump_target,
	output logic mismatch_irq,
	output logic fifo_clear,
	input wire logic ls_targets_ram,
	output logic ls_internal,
	output logic ls_pci_cycle,
	input wire logic master_req,
	input wire logic other_fn_master_busy,
	output logic pci_req_n,
	input wire logic [`PJS_TREE_W-1:0] and_tree_pins,
	input wire logic normal_test_out,
	output logic high_impedance_test,
	output logic test_output_pin,
	output logic test_output_oe,
	input wire logic op_start,
	input wire pjs_op_type op_kind,
	input wire logic [31:0] entry_dword0,
	input wire logic [31:0] entry_dword1,
	input wire logic [31:0] instr_upper,
	input wire logic jump64_load,
	input wire logic [31:0] jump_upper,
	output logic op_done,
	output logic [31:0] addr_upper,
	output logic dac_cycle,
	output logic [23:0] move_byte_count,
	output logic [31:0] move_addr_low
);

	logic [7:0] ctl0_q, ctl0_d;
	logic [7:0] ctl1_q, ctl1_d;
	logic [31:0] mmr_q, mmr_d;
	logic [31:0] mmw_q, mmw_d;
	logic [31:0] fetch_q, fetch_d;
	logic [31:0] rel_q, rel_d;
	logic [31:0] stat_q, stat_d;
	logic [31:0] dyn_q, dyn_d;
	logic [31:0] cur_q, cur_d;
	logic [31:0] rdata_q, rdata_d;
	logic [31:0] scratch_q [16];
	logic scr_hit;
	logic [3:0] scr_idx;
	logic [7:0] scr_off;
	pjs_state_type state_q, state_d;
	logic [2:0] phase_q, phase_d;
	logic wsr_q, wsr_d;
	logic jump_q, jump_d;
	logic [31:0] target_q, target_d;
	logic irq_q, irq_d;
	logic clear_q, clear_d;
	logic done_q, done_d;
	logic [31:0] upper_q, upper_d;
	logic dac_q, dac_d;
	logic [23:0] count_q, count_d;
	logic [31:0] low_q, low_d;
	logic [`PJS_TREE_W-1:0] tree_s1_q, tree_s2_q;
	logic test_q, test_d;
	logic [31:0] sel_value;
	logic data_phase;
	logic outbound;
	logic jump_wanted;

	// Scratch word decode: aligned words from the first scratch offset.
	assign scr_off = reg_addr - `PJS_OFF_SCR_LO;
	assign scr_idx = scr_off[5:2];
	assign scr_hit = (reg_addr >= `PJS_OFF_SCR_LO) && (reg_addr <= `PJS_OFF_SCR_HI)
		&& (reg_addr[1:0] == 2'b00);

	// Phase class of the instruction that was running, never the bus phase.
	assign data_phase = (instr_phase[2:1] == 2'b00); // R4
	assign outbound = ~phase_q[0]; // R4
	assign jump_wanted = ctl0_q[`PJS_B_NONDATA] | data_phase; // R5

	// Picks the upper dword for the operation now being started.
	pjs_sel u_sel (
		.op_kind(op_kind),
		.move_read_selector(mmr_q),
		.move_write_selector(mmw_q),
		.fetch_selector(fetch_q),
		.relative_base_selector(rel_q),
		.static_move_selector(stat_q),
		.dynamic_move_selector(dyn_q),
		.scratch(scratch_q),
		.entry_dword0(entry_dword0),
		.instr_upper(instr_upper),
		.wide_table_move_enable(ctl1_q[`PJS_B_WIDE_TAB]),
		.wide_direct_move_enable(ctl1_q[`PJS_B_WIDE_DIR]),
		.table_index_mode(ctl1_q[`PJS_B_IDX_MODE]),
		.sel_value(sel_value)
	);

	// Register writes; hardware reloads take priority over a write in the same cycle.
	always_comb begin
		ctl0_d = ctl0_q;
		ctl1_d = ctl1_q;
		mmr_d = mmr_q;
		mmw_d = mmw_q;
		fetch_d = fetch_q;
		rel_d = rel_q;
		stat_d = stat_q;
		dyn_d = dyn_q;
		cur_d = cur_q;
		if (reg_wr) begin
			if (reg_addr == `PJS_OFF_CTL0) begin
				ctl0_d = reg_wdata[7:0] & `PJS_CTL0_MASK;
			end else if (reg_addr == `PJS_OFF_CTL1) begin
				ctl1_d = reg_wdata[7:0] & `PJS_CTL1_MASK;
			end else if (reg_addr == `PJS_OFF_MMR) begin
				mmr_d = reg_wdata;
			end else if (reg_addr == `PJS_OFF_MMW) begin
				mmw_d = reg_wdata;
			end else if (reg_addr == `PJS_OFF_FETCH) begin
				fetch_d = reg_wdata;
			end else if (reg_addr == `PJS_OFF_REL) begin
				rel_d = reg_wdata;
			end else if (reg_addr == `PJS_OFF_STAT) begin
				stat_d = reg_wdata;
			end else if (reg_addr == `PJS_OFF_DYN) begin
				dyn_d = reg_wdata;
			end else if (reg_addr == `PJS_OFF_CUR) begin
				cur_d = reg_wdata;
			end
		end
		// A wide jump brings its own fetch upper dword.
		if (jump64_load) begin
			fetch_d = jump_upper; // R21
		end
		if (op_start) begin
			// The current register always shows the selector in use.
			cur_d = sel_value; // R23
			if (op_kind == pjs_op_move_direct && ctl1_q[`PJS_B_WIDE_DIR]) begin
				dyn_d = instr_upper; // R22
			end
		end
	end

	// Read data; everything reads zero while the pins are floated for test.
	always_comb begin
		rdata_d = rdata_q;
		if (reg_rd) begin
			rdata_d = 32'h0000_0000;
			if (ctl1_q[`PJS_B_HIZ]) begin
				rdata_d = 32'h0000_0000; // R9
			end else if (reg_addr == `PJS_OFF_CTL0) begin
				rdata_d = {24'h00_0000, ctl0_q};
			end else if (reg_addr == `PJS_OFF_CTL1) begin
				rdata_d = {24'h00_0000, ctl1_q};
			end else if (scr_hit) begin
				rdata_d = scratch_q[scr_idx];
			end else if (reg_addr == `PJS_OFF_MMR) begin
				rdata_d = mmr_q;
			end else if (reg_addr == `PJS_OFF_MMW) begin
				rdata_d = mmw_q;
			end else if (reg_addr == `PJS_OFF_FETCH) begin
				rdata_d = config_shadow_enable ? {8'h00, REVISION_CODE, DEVICE_CODE}
					: fetch_q; // R21
			end else if (reg_addr == `PJS_OFF_REL) begin
				rdata_d = rel_q;
			end else if (reg_addr == `PJS_OFF_STAT) begin
				rdata_d = stat_q;
			end else if (reg_addr == `PJS_OFF_DYN) begin
				rdata_d = dyn_q;
			end else if (reg_addr == `PJS_OFF_CUR) begin
				rdata_d = cur_q;
			end
		end
	end

	// Mismatch handling: interrupt at once, or wait for residue then jump.
	always_comb begin
		state_d = state_q;
		phase_d = phase_q;
		wsr_d = wsr_q;
		jump_d = 1'b0;
		irq_d = 1'b0;
		clear_d = 1'b0;
		target_d = target_q;
		case (state_q)
			pjs_idle: begin
				if (mismatch_event) begin
					if (ctl0_q[`PJS_B_JUMP_EN] && jump_wanted) begin
						state_d = pjs_calc; // R1
						phase_d = instr_phase; // R4
						wsr_d = wide_residue_flag;
					end else begin
						irq_d = 1'b1; // R5
					end
				end
			end
			pjs_calc: begin
				if (residue_done) begin
					state_d = pjs_idle;
					jump_d = 1'b1; // R1
					if (ctl0_q[`PJS_B_JUMP_SEL]) begin
						target_d = outbound ? jump_address_one : jump_address_two; // R3
					end else begin
						target_d = wsr_q ? jump_address_two : jump_address_one; // R2
					end
					// Leftover send data is dropped once it has been counted.
					clear_d = (phase_q == `PJS_PH_DATA_OUT) && !ctl0_q[`PJS_B_NOCLEAR]; // R6
				end
			end
			default: state_d = pjs_idle;
		endcase
	end

	// Operation results: upper dword, cycle type and table entry fields.
	always_comb begin
		done_d = op_start;
		upper_d = upper_q;
		dac_d = dac_q;
		count_d = count_q;
		low_d = low_q;
		if (op_start) begin
			upper_d = sel_value;
			dac_d = (sel_value != `PJS_SEL_RST) && !ctl1_q[`PJS_B_NO_DAC]; // R16 R10
			if (op_kind == pjs_op_move_table) begin
				count_d = entry_dword0[`PJS_TI_CNT_HI:0]; // R13
				low_d = entry_dword1; // R13
			end
		end
		test_d = ctl1_q[`PJS_B_HIZ] ? (&tree_s2_q) : normal_test_out; // R9
	end

	// Control and selector state; all selectors clear at reset.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctl0_q <= `PJS_CTL0_RST;
			ctl1_q <= `PJS_CTL1_RST;
			mmr_q <= `PJS_SEL_RST; // R17
			mmw_q <= `PJS_SEL_RST;
			fetch_q <= `PJS_SEL_RST;
			rel_q <= `PJS_SEL_RST;
			stat_q <= `PJS_SEL_RST;
			dyn_q <= `PJS_SEL_RST;
			cur_q <= `PJS_SEL_RST;
			rdata_q <= 32'h0000_0000;
			state_q <= pjs_idle;
			phase_q <= 3'h0;
			wsr_q <= 1'b0;
			jump_q <= 1'b0;
			target_q <= 32'h0000_0000;
			irq_q <= 1'b0;
			clear_q <= 1'b0;
			done_q <= 1'b0;
			upper_q <= `PJS_SEL_RST;
			dac_q <= 1'b0;
			count_q <= 24'h00_0000;
			low_q <= 32'h0000_0000;
			tree_s1_q <= '0;
			tree_s2_q <= '0;
			test_q <= 1'b0;
		end else begin
			ctl0_q <= ctl0_d;
			ctl1_q <= ctl1_d;
			mmr_q <= mmr_d;
			mmw_q <= mmw_d;
			fetch_q <= fetch_d;
			rel_q <= rel_d;
			stat_q <= stat_d;
			dyn_q <= dyn_d;
			cur_q <= cur_d;
			rdata_q <= rdata_d;
			state_q <= state_d;
			phase_q <= phase_d;
			wsr_q <= wsr_d;
			jump_q <= jump_d;
			target_q <= target_d;
			irq_q <= irq_d;
			clear_q <= clear_d;
			done_q <= done_d;
			upper_q <= upper_d;
			dac_q <= dac_d;
			count_q <= count_d;
			low_q <= low_d;
			tree_s1_q <= and_tree_pins;
			tree_s2_q <= tree_s1_q;
			test_q <= test_d;
		end
	end

	// Scratch words keep no reset value and change only on a register write.
	always_ff @(posedge core_clk) begin
		if (reg_wr && scr_hit) begin
			scratch_q[scr_idx] <= reg_wdata; // R24
		end
	end

	// Load/store routing and request gating follow the control bits directly.
	assign ls_internal = ls_targets_ram & ~ctl0_q[`PJS_B_NO_INT_LS]; // R7
	assign ls_pci_cycle = ls_targets_ram & ctl0_q[`PJS_B_NO_INT_LS]; // R7
	assign pci_req_n = ~(master_req & ~(ctl0_q[`PJS_B_NO_PREQ] & other_fn_master_busy)); // R8

	// Output drive: the test pin stays driven while every other pin floats.
	assign high_impedance_test = ctl1_q[`PJS_B_HIZ]; // R9
	assign test_output_pin = test_q;
	assign test_output_oe = 1'b1;
	assign reg_rdata = rdata_q;
	assign jump_take = jump_q;
	assign jump_target = target_q;
	assign mismatch_irq = irq_q;
	assign fifo_clear = clear_q;
	assign op_done = done_q;
	assign addr_upper = upper_q;
	assign dac_cycle = dac_q;
	assign move_byte_count = count_q;
	assign move_addr_low = low_q;

endmodule

/* File: bench/pjs_chk.sv */
// Port-level assertions on the selector block.
// Assumes the control registers change only through writes on the register port.
`timescale 1ns/1ps
`include "pjs_cfg.svh"
module pjs_chk import pjs_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic mismatch_event,
	input wire logic [2:0] instr_phase,
	input wire logic mismatch_irq,
	input wire logic jump_take,
	input wire logic fifo_clear,
	input wire logic ls_targets_ram,
	input wire logic ls_internal,
	input wire logic ls_pci_cycle,
	input wire logic master_req,
	input wire logic other_fn_master_busy,
	input wire logic pci_req_n,
	input wire logic high_impedance_test,
	input wire logic op_start,
	input wire logic op_done,
	input wire logic [31:0] addr_upper,
	input wire logic dac_cycle
);
	logic [7:0] c0_q, c0_d, c1_q, c1_d;
	// Shadows of both control registers, followed from port writes.
	always_comb begin
		c0_d = c0_q;
		c1_d = c1_q;
		if (reg_wr && reg_addr == `PJS_OFF_CTL0) c0_d = reg_wdata[7:0] & `PJS_CTL0_MASK;
		if (reg_wr && reg_addr == `PJS_OFF_CTL1) c1_d = reg_wdata[7:0] & `PJS_CTL1_MASK;
	end
	// Registers the shadows.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			c0_q <= 8'h00;
			c1_q <= 8'h00;
		end else begin
			c0_q <= c0_d;
			c1_q <= c1_d;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_hiz_rd;
		reg_rd && c1_q[7];
	endsequence
	sequence s_op;
		op_start ##1 !op_start;
	endsequence
	property p_irq;
		mismatch_irq |-> $past(mismatch_event) && !jump_take && (!$past(c0_q[7])
			|| ($past(instr_phase[2:1]) != 2'b00 && !$past(c0_q[5])));
	endproperty
	property p_jump;
		jump_take |-> c0_q[7] && !mismatch_irq;
	endproperty
	property p_fifo;
		fifo_clear |-> jump_take && !c0_q[4];
	endproperty
	property p_ls;
		ls_targets_ram |-> ls_internal == !c0_q[1] && ls_pci_cycle == c0_q[1];
	endproperty
	property p_req;
		pci_req_n == !(master_req && !(c0_q[0] && other_fn_master_busy));
	endproperty
	property p_hiz;
		s_hiz_rd |-> ##2 reg_rdata == 32'h0 && high_impedance_test;
	endproperty
	property p_dac;
		op_done |-> dac_cycle == (addr_upper != 32'h0 && !$past(c1_q[3]));
	endproperty
	property p_op;
		s_op |-> op_done ##1 !op_done;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt without cause");
	a_jump: assert property (p_jump) else $error("jump while disabled");
	a_fifo: assert property (p_fifo) else $error("wrong fifo clear");
	a_ls: assert property (p_ls) else $error("wrong load store route");
	a_req: assert property (p_req) else $error("wrong bus request");
	a_hiz: assert property (p_hiz) else $error("read in test mode not zero");
	a_dac: assert property (p_dac) else $error("wrong address cycle kind");
	a_op: assert property (p_op) else $error("operation done missing");
endmodule
bind pjs_top pjs_chk i_chk (.core_clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
	.reg_rdata, .mismatch_event, .instr_phase, .mismatch_irq, .jump_take, .fifo_clear,
	.ls_targets_ram, .ls_internal, .ls_pci_cycle, .master_req, .other_fn_master_busy,
	.pci_req_n, .high_impedance_test, .op_start, .op_done, .addr_upper, .dac_cycle);

/* File: bench/pjs_pci_model.sv */
// Model of the other PCI function and of the address cycles seen by the targets.
// Assumes op_done marks each master address phase of this function.
`timescale 1ns/1ps
module pjs_pci_model import pjs_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic hold_bus,
	input wire logic op_done,
	input wire logic dac_cycle,
	output logic other_fn_master_busy,
	output int n_dac
);
	// The other function masters when asked and dual address cycles are counted.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			other_fn_master_busy <= 1'b0;
			n_dac <= 0;
		end else begin
			other_fn_master_busy <= hold_bus;
			if (op_done && dac_cycle) n_dac <= n_dac + 1;
		end
	end
endmodule

/* File: bench/testbench.sv */
// Self-checking bench of the selector block with its PCI-side model.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
module testbench import pjs_pkg::*; ;
	localparam logic [15:0] DEV = 16'h5a3c; // Arbitrary value.
	localparam logic [7:0] REV = 8'h2e; // Arbitrary value.
	logic core_clk, rst, reg_wr, reg_rd, config_shadow_enable, mismatch_event, wide_residue_flag;
	logic residue_done, ls_targets_ram, master_req, hold_bus, normal_test_out, op_start, jump64_load;
	logic jump_take, mismatch_irq, fifo_clear, ls_internal, ls_pci_cycle, other_fn_master_busy;
	logic pci_req_n, high_impedance_test, test_output_pin, test_output_oe, op_done, dac_cycle;
	logic [7:0] reg_addr, c0, c1;
	logic [2:0] instr_phase;
	logic [15:0] and_tree_pins;
	logic [23:0] move_byte_count;
	logic [31:0] reg_wdata, reg_rdata, jump_address_one, jump_address_two, jump_target, v;
	logic [31:0] entry_dword0, entry_dword1, instr_upper, jump_upper, addr_upper, move_addr_low;
	logic [31:0] sel [6];
	logic [31:0] scr [16];
	pjs_op_type op_kind;
	int n_tests, n_mismatch, nd, n_dac, i, j;
	pjs_top #(.DEVICE_CODE(DEV), .REVISION_CODE(REV)) i_dut (.core_clk, .rst, .reg_addr, .reg_wr,
		.reg_rd, .reg_wdata, .reg_rdata, .config_shadow_enable, .mismatch_event, .instr_phase,
		.wide_residue_flag, .residue_done, .jump_address_one, .jump_address_two, .jump_take,
		.jump_target, .mismatch_irq, .fifo_clear, .ls_targets_ram, .ls_internal, .ls_pci_cycle,
		.master_req, .other_fn_master_busy, .pci_req_n, .and_tree_pins, .normal_test_out,
		.high_impedance_test, .test_output_pin, .test_output_oe, .op_start, .op_kind,
		.entry_dword0, .entry_dword1, .instr_upper, .jump64_load, .jump_upper, .op_done,
		.addr_upper, .dac_cycle, .move_byte_count, .move_addr_low);
	pjs_pci_model i_pci (.core_clk, .rst, .hold_bus, .op_done, .dac_cycle,
		.other_fn_master_busy, .n_dac);
	// Clock of 25 ns.
	always #12.5 core_clk = ~core_clk;
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Register writes happen only while no operation runs.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask
	task automatic wsel(input int k, input logic [31:0] d);
		sel[k] = d;
		wr(8'ha0 + 8'(4 * k), d);
	endtask
	task automatic wc0(input logic [7:0] d);
		c0 = d & 8'hf3;
		wr(8'h56, {24'h0, d});
	endtask
	task automatic wc1(input logic [7:0] d);
		c1 = d & 8'h8f;
		wr(8'h57, {24'h0, d});
	endtask
	// Upper address dword that an operation should pick.
	function automatic logic [31:0] exp_sel(pjs_op_type k, logic [31:0] d0, logic [31:0] iu);
		logic [4:0] ix;
		ix = d0[28:24];
		case (k)
			pjs_op_fetch, pjs_op_ind_fetch: return sel[2];
			pjs_op_table_fetch, pjs_op_rel_ls: return sel[3];
			pjs_op_mm_read, pjs_op_abs_load: return sel[0];
			pjs_op_mm_write, pjs_op_abs_store: return sel[1];
			pjs_op_move_direct: return c1[0] ? iu : sel[4];
			pjs_op_move_indirect: return sel[4];
			default: begin
				if (!c1[1]) return sel[4];
				if (c1[2]) return {24'h0, d0[31:24]};
				if (ix < 5'd6) return sel[ix];
				if (ix < 5'd22) return scr[ix - 5'd6];
				return 32'h0;
			end
		endcase
	endfunction
	// One master operation; operations never cross an upper dword boundary.
	task automatic op(input pjs_op_type k, input logic [31:0] d0, input logic [31:0] d1,
		input logic [31:0] iu);
		logic [31:0] e;
		e = exp_sel(k, d0, iu);
		if (e != 32'h0 && !c1[3]) nd++;
		@(negedge core_clk);
		op_start = 1'b1;
		op_kind = k;
		entry_dword0 = d0;
		entry_dword1 = d1;
		instr_upper = iu;
		@(negedge core_clk);
		op_start = 1'b0;
		chk(addr_upper, e);
		chk({31'h0, dac_cycle}, {31'h0, e != 32'h0 && !c1[3]});
		if (k == pjs_op_move_table) begin
			chk({move_byte_count, 8'h0}, {d0[23:0], 8'h0});
			chk(move_addr_low, d1);
		end
		if (k == pjs_op_move_direct && c1[0]) sel[5] = iu;
		rd(8'hb8, v);
		chk(v, e);
	endtask
	// One phase mismatch carried through to interrupt or jump.
	task automatic mm(input logic [2:0] ph, input logic w);
		logic [31:0] a1, a2;
		logic go;
		a1 = $urandom();
		a2 = $urandom();
		go = c0[7] && (ph[2:1] == 2'b00 || c0[5]);
		@(negedge core_clk);
		mismatch_event = 1'b1;
		instr_phase = ph;
		wide_residue_flag = w;
		jump_address_one = a1;
		jump_address_two = a2;
		@(negedge core_clk);
		mismatch_event = 1'b0;
		wide_residue_flag = !w;
		chk({31'h0, mismatch_irq}, {31'h0, !go});
		if (go) begin
			@(negedge core_clk);
			residue_done = 1'b1;
			@(negedge core_clk);
			residue_done = 1'b0;
			chk({31'h0, jump_take}, 32'h1);
			chk(jump_target, (c0[6] ? ph[0] : w) ? a2 : a1);
			chk({31'h0, fifo_clear}, {31'h0, ph == 3'h0 && !c0[4]});
		end
	endtask
	// Cuts a hang short.
	initial begin
		repeat (40000) @(posedge core_clk);
		n_mismatch++;
		end_of_test();
	end
	// Main sequence of scenarios.
	initial begin
		{core_clk, reg_wr, reg_rd, config_shadow_enable, mismatch_event, wide_residue_flag} = '0;
		{residue_done, ls_targets_ram, master_req, hold_bus, normal_test_out, op_start} = '0;
		{jump64_load, reg_addr, instr_phase, and_tree_pins, reg_wdata, jump_upper} = '0;
		{jump_address_one, jump_address_two, entry_dword0, entry_dword1, instr_upper} = '0;
		op_kind = pjs_op_fetch;
		{n_tests, n_mismatch, nd, c0, c1} = '0;
		rst = 1'b1;
		v = $urandom(82787);
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		for (i = 0; i < 9; i++) begin
			rd(i < 7 ? 8'ha0 + 8'(4 * i) : 8'h4f + 8'(i), v);
			chk(v, 32'h0);
		end
		for (i = 0; i < 6; i++) wsel(i, $urandom());
		for (i = 0; i < 16; i++) begin
			scr[i] = $urandom();
			wr(8'h60 + 8'(4 * i), scr[i]);
		end
		for (i = 0; i < 22; i++) begin
			rd(i < 6 ? 8'ha0 + 8'(4 * i) : 8'h48 + 8'(4 * i), v);
			chk(v, i < 6 ? sel[i] : scr[i - 6]);
		end
		wr(8'hbc, $urandom());
		rd(8'hbc, v);
		chk(v, 32'h0);
		wc0(8'hff);
		rd(8'h56, v);
		chk(v, 32'hf3);
		wc1(8'h7f);
		rd(8'h57, v);
		chk(v, 32'h0f);
		config_shadow_enable = 1'b1;
		rd(8'ha8, v);
		chk(v, {8'h00, REV, DEV});
		rd(8'ha0, v);
		chk(v, sel[0]);
		config_shadow_enable = 1'b0;
		jump64_load = 1'b1;
		jump_upper = $urandom();
		sel[2] = jump_upper;
		@(negedge core_clk);
		jump64_load = 1'b0;
		rd(8'ha8, v);
		chk(v, sel[2]);
		// Table indices 0 to 23 first, then random operations under random controls.
		wc1(8'h02);
		for (i = 0; i < 60; i++) begin
			if (i >= 24 && i % 6 == 0) wc1(8'($urandom()) & 8'h0f);
			v = $urandom();
			if (i < 24) v[28:24] = 5'(i);
			op(i < 24 ? pjs_op_move_table : pjs_op_type'($urandom_range(10)), v, $urandom(),
				$urandom());
		end
		rd(8'hb0, v);
		chk(v, sel[4]);
		rd(8'hb4, v);
		chk(v, sel[5]);
		chk(32'(n_dac), 32'(nd));
		for (i = 0; i < 16; i++) begin
			wc0(8'(i << 4));
			for (j = 0; j < 8; j++) if (j != 4 && j != 5) mm(3'(j), 1'($urandom()));
		end
		// Request and load store routing under random controls and partner activity.
		for (i = 0; i < 24; i++) begin
			wc0(8'($urandom()) & 8'h03);
			{ls_targets_ram, master_req, hold_bus, normal_test_out} = 4'($urandom());
			@(negedge core_clk);
			chk({31'h0, pci_req_n}, {31'h0, !(master_req && !(c0[0] && hold_bus))});
			chk({30'h0, ls_internal, ls_pci_cycle},
				{30'h0, ls_targets_ram && !c0[1], ls_targets_ram && c0[1]});
			chk({31'h0, test_output_pin}, {31'h0, normal_test_out});
		end
		// Test mode: the AND tree drives the test pin and reads give zero.
		and_tree_pins = 16'hffff;
		wc1(8'h80);
		repeat (4) @(negedge core_clk);
		chk({30'h0, test_output_pin, test_output_oe}, 32'h3);
		and_tree_pins = ~(16'h1 << $urandom_range(15));
		repeat (4) @(negedge core_clk);
		chk({30'h0, test_output_pin, high_impedance_test}, 32'h1);
		rd(8'ha0, v);
		chk(v, 32'h0);
		wc1(8'h00);
		rd(8'ha0, v);
		chk(v, sel[0]);
		end_of_test();
	end
endmodule
